// File: shared/sea_pkg.sv
package sea_pkg;
  localparam int        DW            = 16;
  localparam logic [15:0] UNDERFLOW_BOUND = 16'h0800;
  localparam logic [15:0] WORD_STEP     = 16'h0002;
  localparam logic [15:0] NEAR_LIMIT    = 16'h2000;
  localparam int        FILE_ADDR_W   = 13;
  localparam int        SHORT_LIT_W   = 5;
  localparam int        OFFS_FIELD_W  = 4;
  localparam int        BRANCH_LIT_W  = 16;
  localparam int        INTERRUPT_DISABLE_INSTR_LIT_W    = 14;
  localparam int        SP_INDEX      = 15;
  localparam int        DEFAULT_INDEX = 0;

  typedef enum logic [2:0] {
    SEA_REG_DIRECT,
    SEA_IND,
    SEA_IND_POST,
    SEA_IND_PRE,
    SEA_INDEXED,
    SEA_LIT_OFFSET,
    SEA_FILE_DIRECT,
    SEA_LITERAL
  } sea_mode_e;

  typedef enum logic [2:0] {
    SEA_OP_NONE,
    SEA_OP_EA,
    SEA_OP_PUSH,
    SEA_OP_POP,
    SEA_OP_CALL_PUSH,
    SEA_OP_EXC_PUSH
  } sea_op_e;
endpackage

// File: hdl/sea_core.sv
`timescale 1ns/1ps
module sea_core
  import sea_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    op_valid,
  input  wire sea_op_e                 op_kind,
  input  wire sea_mode_e               src_mode,
  input  wire sea_mode_e               dst_mode,
  input  wire logic                    is_move_instr,
  input  wire logic [3:0]              pointer_src_sel,
  input  wire logic [3:0]              pointer_dst_sel,
  input  wire logic [OFFS_FIELD_W-1:0] offset_work_sel,
  input  wire logic [15:0]             pointer_src_val,
  input  wire logic [15:0]             pointer_dst_val,
  input  wire logic [15:0]             offset_work_val,
  input  wire logic [15:0]             mod_const,
  input  wire logic [15:0]             lit_offset,
  input  wire logic [FILE_ADDR_W-1:0]  file_addr,
  input  wire logic [15:0]             move_abs_addr,
  input  wire logic                    file_dest_implied_work_reg,
  input  wire logic [SHORT_LIT_W-1:0]  short_lit,
  input  wire logic [BRANCH_LIT_W-1:0] branch_lit,
  input  wire logic [INTERRUPT_DISABLE_INSTR_LIT_W-1:0]   interrupt_disable_instr_lit,
  input  wire logic [22:0]             pc_val,
  input  wire logic [7:0]              status_low_byte,
  input  wire logic [15:0]             sp_write_val,
  input  wire logic                    sp_write,
  input  wire logic [15:0]             limit_write_val,
  input  wire logic                    limit_write,
  input  wire logic                    boot_ram_en,
  input  wire logic [15:0]             boot_ram_lo,
  input  wire logic [15:0]             boot_ram_hi,
  input  wire logic                    secure_ram_en,
  input  wire logic [15:0]             secure_ram_lo,
  input  wire logic [15:0]             secure_ram_hi,
  input  wire logic                    exec_in_boot,
  input  wire logic                    exec_in_secure,
  output logic [15:0]                  src_ea,
  output logic [15:0]                  dst_ea,
  output logic [15:0]                  ptr_src_upd,
  output logic                         ptr_src_upd_en,
  output logic [15:0]                  ptr_dst_upd,
  output logic                         ptr_dst_upd_en,
  output logic [3:0]                   result_dest_sel,
  output logic [15:0]                  operand2_lit,
  output logic [15:0]                  branch_offset,
  output logic [15:0]                  interrupt_disable_instr_count,
  output logic [15:0]                  stack_addr,
  output logic [15:0]                  push_lo_word,
  output logic [15:0]                  push_hi_word,
  output logic [15:0]                  stack_pointer_reg,
  output logic                         stack_err_trap,
  output logic                         ram_access_refused
);
  logic [15:0] sp_ff, nxt_sp;
  logic [15:0] stack_limit_reg, nxt_limit;
  logic        ovf, unf, sp_src, sp_dst, src_mem, dst_mem;
  logic        boot_hit, sec_hit;

  // effective address per operand; mode decode shared by source and destination
  function automatic logic [15:0] ea_of(input sea_mode_e m, input logic [15:0] p,
                                        input logic [15:0] ofs, input logic [15:0] k,
                                        input logic [15:0] lit, input logic [15:0] fa,
                                        input logic [15:0] abs_a, input logic mv);
    logic [15:0] r;
    r = p;
    unique case (m)
      SEA_IND,
      SEA_IND_POST:   r = p;
      SEA_IND_PRE:    r = p + k;
      SEA_INDEXED:    r = p + ofs;
      SEA_LIT_OFFSET: r = p + lit;
      SEA_FILE_DIRECT: r = mv ? abs_a : fa;
      SEA_REG_DIRECT,
      SEA_LITERAL:    r = 16'h0000;
    endcase
    return r;
  endfunction

  function automatic logic is_mem(input sea_mode_e m);
    return !(m == SEA_REG_DIRECT || m == SEA_LITERAL);
  endfunction

  always_comb
  begin
    // both sides read the one shared offset register value
    src_ea = ea_of(src_mode, pointer_src_val, offset_work_val, mod_const, lit_offset,
                   {3'h0, file_addr}, move_abs_addr, is_move_instr);
    dst_ea = ea_of(dst_mode, pointer_dst_val, offset_work_val, mod_const, lit_offset,
                   {3'h0, file_addr}, move_abs_addr, is_move_instr);
    ptr_src_upd    = pointer_src_val + mod_const;
    ptr_dst_upd    = pointer_dst_val + mod_const;
    ptr_src_upd_en = op_valid && op_kind == SEA_OP_EA &&
                     (src_mode == SEA_IND_POST || src_mode == SEA_IND_PRE);
    ptr_dst_upd_en = op_valid && op_kind == SEA_OP_EA &&
                     (dst_mode == SEA_IND_POST || dst_mode == SEA_IND_PRE);
    result_dest_sel = file_dest_implied_work_reg ? 4'(DEFAULT_INDEX) : offset_work_sel;
    operand2_lit  = {{(16-SHORT_LIT_W){1'b0}}, short_lit};
    branch_offset = branch_lit;
    interrupt_disable_instr_count    = {{(16-INTERRUPT_DISABLE_INSTR_LIT_W){1'b0}}, interrupt_disable_instr_lit};
  end

  always_comb
  begin
    nxt_sp    = sp_ff;
    nxt_limit = stack_limit_reg;
    stack_addr = sp_ff;
    if (limit_write)
      nxt_limit = {limit_write_val[15:1], 1'b0};
    if (sp_write)
      nxt_sp = {sp_write_val[15:1], 1'b0};
    else if (op_valid)
    begin
      unique case (op_kind)
        SEA_OP_PUSH,
        SEA_OP_CALL_PUSH,
        SEA_OP_EXC_PUSH: nxt_sp = sp_ff + WORD_STEP;
        SEA_OP_POP:
        begin
          nxt_sp     = sp_ff - WORD_STEP;
          stack_addr = sp_ff - WORD_STEP;
        end
        default: nxt_sp = sp_ff;
      endcase
    end
    // pc pushes span two words; this model pushes them as one transaction
    push_lo_word = pc_val[15:0];
    push_hi_word = 16'h0000;
    if (op_kind == SEA_OP_CALL_PUSH)
      push_hi_word = {9'h000, 1'b0, pc_val[21:16]};
    else if (op_kind == SEA_OP_EXC_PUSH)
      push_hi_word = {status_low_byte, 1'b0, pc_val[22:16]};
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      sp_ff <= UNDERFLOW_BOUND;
    else
      sp_ff <= nxt_sp;
  end

  // limit is deliberately left out of reset
  always_ff @(posedge ref_clk)
  begin
    stack_limit_reg <= nxt_limit;
  end

  always_comb
  begin
    sp_src  = pointer_src_sel == 4'(SP_INDEX) && is_mem(src_mode);
    sp_dst  = pointer_dst_sel == 4'(SP_INDEX) && is_mem(dst_mode);
    src_mem = is_mem(src_mode);
    dst_mem = is_mem(dst_mode);
    ovf = 1'b0;
    unf = 1'b0;
    if (op_valid)
    begin
      unique case (op_kind)
        SEA_OP_PUSH,
        SEA_OP_CALL_PUSH,
        SEA_OP_EXC_PUSH:
        begin
          ovf = sp_ff > stack_limit_reg;
          unf = sp_ff < UNDERFLOW_BOUND;
        end
        SEA_OP_POP: unf = (sp_ff - WORD_STEP) < UNDERFLOW_BOUND;
        SEA_OP_EA:
        begin
          // a limit written the cycle before is already in the compare
          ovf = (sp_src && src_ea > stack_limit_reg) ||
                (sp_dst && dst_ea > stack_limit_reg);
          unf = (sp_src && src_ea < UNDERFLOW_BOUND) ||
                (sp_dst && dst_ea < UNDERFLOW_BOUND);
        end
        default:
        begin
          ovf = 1'b0;
          unf = 1'b0;
        end
      endcase
    end
    stack_err_trap = ovf || unf;
    boot_hit = boot_ram_en && !exec_in_boot &&
               ((src_mem && src_ea >= boot_ram_lo && src_ea <= boot_ram_hi) ||
                (dst_mem && dst_ea >= boot_ram_lo && dst_ea <= boot_ram_hi));
    sec_hit  = secure_ram_en && !exec_in_secure &&
               ((src_mem && src_ea >= secure_ram_lo && src_ea <= secure_ram_hi) ||
                (dst_mem && dst_ea >= secure_ram_lo && dst_ea <= secure_ram_hi));
    ram_access_refused = op_valid && op_kind == SEA_OP_EA && (boot_hit || sec_hit);
  end

  assign stack_pointer_reg = sp_ff;

endmodule // sea_core

// File: tb/sea_core_asserts.sv
`timescale 1ns/1ps
module sea_core_chk
  import sea_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        op_valid,
  input wire sea_op_e     op_kind,
  input wire logic        sp_write,
  input wire logic [22:0] pc_val,
  input wire logic [7:0]  status_low_byte,
  input wire logic [15:0] stack_addr,
  input wire logic [15:0] push_lo_word,
  input wire logic [15:0] push_hi_word,
  input wire logic [15:0] stack_pointer_reg,
  input wire logic        stack_err_trap
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_push_at_sp: assert property (op_valid && op_kind == SEA_OP_PUSH |-> stack_addr == stack_pointer_reg)
    else $error("push address is not the stack pointer");
  a_push_post_inc: assert property (op_valid && op_kind == SEA_OP_PUSH && !sp_write |=> stack_pointer_reg == $past(stack_pointer_reg) + WORD_STEP)
    else $error("push did not advance the stack pointer");
  a_pop_pre_dec: assert property (op_valid && op_kind == SEA_OP_POP && !sp_write |=> stack_pointer_reg == $past(stack_pointer_reg) - WORD_STEP)
    else $error("pop did not retreat the stack pointer");
  a_call_top_clear: assert property (op_valid && op_kind == SEA_OP_CALL_PUSH |-> push_hi_word[15:6] == 10'h000 && push_lo_word == pc_val[15:0])
    else $error("call push words wrong");
  a_exc_status: assert property (op_valid && op_kind == SEA_OP_EXC_PUSH |-> push_hi_word == {status_low_byte, 1'b0, pc_val[22:16]})
    else $error("exception push word wrong");
  a_low_trap: assert property (op_valid && op_kind == SEA_OP_PUSH && stack_pointer_reg < UNDERFLOW_BOUND |-> stack_err_trap)
    else $error("underflow not trapped");
  a_trap_with_op: assert property (stack_err_trap |-> op_valid && op_kind != SEA_OP_NONE)
    else $error("trap without an operation");
  a_sp_reset: assert property ($fell(rst) |-> stack_pointer_reg == UNDERFLOW_BOUND)
    else $error("stack pointer reset value wrong");
endmodule // sea_core_chk

bind sea_core sea_core_chk u_chk (.*);

// File: tb/sea_far_model.sv
`timescale 1ns/1ps
module sea_far_model (
  input  wire logic  ref_clk,
  input  wire logic  rst,
  input  wire logic  stack_err_trap,
  output logic [15:0] trap_cnt
);
  // exception logic takes one trap for every cycle the request is high
  always_ff @(posedge ref_clk)
    trap_cnt <= rst ? 16'h0000 : trap_cnt + 16'(stack_err_trap);
endmodule // sea_far_model

// File: tb/stack_check_and_ea_generation_bench.sv
`timescale 1ns/1ps
module stack_check_and_ea_generation_bench;
  import sea_pkg::*;
  logic ref_clk = 0, rst = 1, op_valid = 0, is_move_instr = 0, file_dest_implied_work_reg = 0, sp_write = 0;
  logic limit_write = 0, boot_ram_en = 0, secure_ram_en = 0, exec_in_boot = 0, exec_in_secure = 0;
  logic ptr_src_upd_en, ptr_dst_upd_en, stack_err_trap, ram_access_refused, t;
  sea_op_e op_kind = SEA_OP_NONE;
  sea_mode_e src_mode = SEA_IND, dst_mode = SEA_INDEXED;
  logic [3:0] pointer_src_sel = 0, pointer_dst_sel = 0, offset_work_sel = 0, result_dest_sel;
  logic [15:0] pointer_src_val = 0, pointer_dst_val = 0, offset_work_val = 0, mod_const = 0;
  logic [15:0] lit_offset = 0, move_abs_addr = 0, branch_lit = 0, sp_write_val = 0;
  logic [15:0] limit_write_val = 0, boot_ram_lo = 0, boot_ram_hi = 0, secure_ram_lo = 0;
  logic [15:0] secure_ram_hi = 0, src_ea, dst_ea, ptr_src_upd, ptr_dst_upd, operand2_lit;
  logic [15:0] branch_offset, interrupt_disable_instr_count, stack_addr, push_lo_word, push_hi_word;
  logic [15:0] stack_pointer_reg, trap_cnt, sp_m, lim_m, tcnt_m, e;
  logic [12:0] file_addr = 0;
  logic [4:0] short_lit = 0;
  logic [13:0] interrupt_disable_instr_lit = 0;
  logic [22:0] pc_val = 0;
  logic [7:0] status_low_byte = 0;
  int seed = 48143, bad_count = 0, tests_run = 0;
  sea_core u_dut (.*);
  sea_far_model u_far (.*);
  initial forever #20 ref_clk = ~ref_clk;
  function automatic logic [15:0] r16();
    return 16'($random(seed));
  endfunction
  task automatic nxt();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic stk(input sea_op_e k);
    e = (k == SEA_OP_POP) ? sp_m - WORD_STEP : sp_m;
    t = e < UNDERFLOW_BOUND || (k != SEA_OP_POP && e > lim_m);
    op_kind = k;
    #5;
    chk(stack_addr, e);
    chk(16'(stack_err_trap), 16'(t));
    tcnt_m += 16'(t);
    nxt();
    sp_m = (k == SEA_OP_POP) ? e : sp_m + WORD_STEP;
    chk(stack_pointer_reg, sp_m);
  endtask
  initial
  begin
    repeat (12) nxt();
    rst = 0;
    op_valid = 1;
    sp_m = UNDERFLOW_BOUND;
    tcnt_m = 0;
    chk(stack_pointer_reg, sp_m);
    limit_write_val = 16'h0805;
    limit_write = 1;
    nxt();
    limit_write = 0;
    lim_m = 16'h0804;
    // four pushes reach the limit and one past it, pops run below the floor
    for (int i = 0; i < 10; i++)
      stk(((10'h20F >> i) & 1) ? SEA_OP_PUSH : SEA_OP_POP);
    op_kind = SEA_OP_NONE;
    sp_write_val = 16'h0A01;
    sp_write = 1;
    nxt();
    sp_write = 0;
    sp_m = 16'h0A00;
    chk(stack_pointer_reg, sp_m);
    for (int i = 0; i < 4; i++)
    begin
      pc_val = 23'({r16(), r16()});
      status_low_byte = 8'(r16());
      stk(i[0] ? SEA_OP_EXC_PUSH : SEA_OP_CALL_PUSH);
      chk(push_lo_word, pc_val[15:0]);
      chk(push_hi_word, i[0] ? {status_low_byte, 1'b0, pc_val[22:16]} : {10'h000, pc_val[21:16]});
    end
    op_kind = SEA_OP_EA;
    for (int i = 0; i < 48; i++)
    begin
      src_mode = sea_mode_e'(i % 6 + 1);
      pointer_src_sel = 4'(i % 15);
      pointer_dst_sel = 4'(i % 13);
      {pointer_src_val, pointer_dst_val, offset_work_val, mod_const} = {r16(), r16(), r16(), r16()};
      {lit_offset, move_abs_addr, branch_lit} = {r16(), r16(), r16()};
      {file_addr, short_lit, interrupt_disable_instr_lit} = 32'({r16(), r16()});
      {offset_work_sel, is_move_instr, file_dest_implied_work_reg} = 6'(r16());
      case (src_mode)
        SEA_IND_PRE: e = pointer_src_val + mod_const;
        SEA_INDEXED: e = pointer_src_val + offset_work_val;
        SEA_LIT_OFFSET: e = pointer_src_val + lit_offset;
        SEA_FILE_DIRECT: e = is_move_instr ? move_abs_addr : 16'(file_addr);
        default: e = pointer_src_val;
      endcase
      #5;
      chk(src_ea, e);
      chk(dst_ea, pointer_dst_val + offset_work_val);
      if (src_mode inside {SEA_IND_POST, SEA_IND_PRE})
        chk(ptr_src_upd, pointer_src_val + mod_const);
      chk(16'(ptr_src_upd_en), 16'(src_mode inside {SEA_IND_POST, SEA_IND_PRE}));
      chk(16'(ptr_dst_upd_en), 16'h0000);
      chk(ptr_dst_upd, pointer_dst_val + mod_const);
      chk(16'(result_dest_sel), 16'(file_dest_implied_work_reg ? 4'h0 : offset_work_sel));
      chk(operand2_lit, 16'(short_lit));
      chk(branch_offset, branch_lit);
      chk(interrupt_disable_instr_count, 16'(interrupt_disable_instr_lit));
      nxt();
    end
    src_mode = SEA_IND;
    offset_work_val = 0;
    boot_ram_lo = 16'h0900;
    boot_ram_hi = 16'h09FF;
    secure_ram_lo = 16'h0A00;
    secure_ram_hi = 16'h0AFF;
    for (int i = 0; i < 32; i++)
    begin
      {boot_ram_en, exec_in_boot, secure_ram_en, exec_in_secure} = 4'(i);
      pointer_src_val = i[4] ? 16'h0A40 : 16'h0940;
      pointer_dst_val = pointer_src_val;
      #5;
      chk(16'(ram_access_refused), 16'(i[4] ? secure_ram_en && !exec_in_secure : boot_ram_en && !exec_in_boot));
      nxt();
    end
    // stack pointer as source pointer: above limit, below floor, at limit
    pointer_src_sel = 4'(SP_INDEX);
    for (int i = 0; i < 3; i++)
    begin
      pointer_src_val = i[1] ? 16'h0804 : (i[0] ? 16'h07FE : 16'h0806);
      t = i < 2;
      #5;
      chk(16'(stack_err_trap), 16'(t));
      tcnt_m += 16'(t);
      nxt();
    end
    chk(trap_cnt, tcnt_m);
    end_of_test();
  end
  initial
  begin
    #200000;
    bad_count++;
    end_of_test();
  end
endmodule // stack_check_and_ea_generation_bench
